// >>> sample_int_status_and_pin_cfg_tb_top.sv
// Self-checking bench for the interrupt status and pin configuration block.
// Assumes sics_pkg, sics_pin_if, sics_pin_drive and sics_int_status are compiled first.
`timescale 1ns/100ps
module sample_int_status_and_pin_cfg_tb_top;
	import sics_pkg::*;
	typedef struct packed {
		sics_word_t mask;
		sics_word_t cfg;
		logic [6:0] cnt;
		logic [5:0] thr;
		logic [1:0] ev;
		sics_word_t stat;
		logic [3:0] pins;
	} sics_case_t;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic regWrEn = 1'b0;
	logic regRdEn = 1'b0;
	sics_addr_t regAddr = 8'h00;
	sics_word_t regWrData = 16'h0000;
	sics_word_t regRdData;
	sics_word_t cfgNow = 16'h0000;
	logic [6:0] cnt = 7'h00;
	logic [5:0] thr = 6'h00;
	logic evA = 1'b0;
	logic evB = 1'b0;
	logic clrReq, zOut, zOe, oOut, oOe, zLvl, oLvl;
	int failures = 0;
	int n_checks = 0;
	int cycles = 0;
	// Pins are {zero level, zero drive, one level, one drive}, levels as the host senses them.
	sics_case_t rows [7] = '{
		'{16'h01FF, 16'h0000, 7'h00, 6'h00, 2'b01, 16'h0020, 4'b0001},
		'{16'h01DF, 16'h0000, 7'h00, 6'h00, 2'b01, 16'h0020, 4'b0011},
		'{16'h01BF, 16'h0105, 7'h00, 6'h00, 2'b10, 16'h0040, 4'b0101},
		'{16'h01BF, 16'h0207, 7'h00, 6'h00, 2'b01, 16'h0020, 4'b1000},
		'{16'h00FF, 16'h0206, 7'h7F, 6'h3F, 2'b00, 16'hFE00, 4'b1111},
		'{16'h00FF, 16'h0206, 7'h3F, 6'h3F, 2'b00, 16'h7E00, 4'b0000},
		'{16'h019F, 16'h0000, 7'h00, 6'h00, 2'b11, 16'h0060, 4'b0011}};

	sics_int_status #(.WORD_CNT_W(7), .THR_W(6)) u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
		.regRdData(regRdData), .bufferWordCount(cnt), .bufferWordThreshold(thr),
		.firstSlotEvent(evA), .secondSlotEvent(evB), .bufferClearReq(clrReq),
		.intPinZeroOut(zOut), .intPinZeroOe(zOe), .intPinOneOut(oOut), .intPinOneOe(oOe));
	sics_host_model u_hostZero (.pinOut(zOut), .pinOe(zOe), .pullLevel(cfgNow[0]),
		.pinLevel(zLvl));
	sics_host_model u_hostOne (.pinOut(oOut), .pinOe(oOe), .pullLevel(cfgNow[8]),
		.pinLevel(oLvl));

	// ****************************************
	// Bus cycles and comparisons
	// ****************************************
	task automatic chkW(input string nm, input sics_word_t e, input sics_word_t g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chkP(input string nm, input logic [3:0] e, input logic [3:0] g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s: expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic wr(input sics_addr_t a, input sics_word_t d);
		@(posedge ref_clk);
		regWrEn <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge ref_clk);
		regWrEn <= 1'b0;
	endtask
	task automatic rdchk(input string nm, input sics_addr_t a, input sics_word_t e);
		@(posedge ref_clk);
		regRdEn <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRdEn <= 1'b0;
		#1 chkW(nm, e, regRdData);
	endtask
	task automatic conclude;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures++;
			conclude();
		end
	end

	initial begin
		repeat (12) @(posedge ref_clk);
		sys_rst <= 1'b0;
		foreach (rows[i]) begin
			@(posedge ref_clk);
			cnt <= rows[i].cnt;
			thr <= rows[i].thr;
			wr(8'h01, rows[i].mask);
			wr(8'h02, rows[i].cfg);
			cfgNow <= rows[i].cfg;
			wr(8'h00, 16'h0060);
			@(posedge ref_clk);
			evA <= rows[i].ev[0];
			evB <= rows[i].ev[1];
			@(posedge ref_clk);
			evA <= 1'b0;
			evB <= 1'b0;
			repeat (3) @(posedge ref_clk);
			#1 chkP("pins", rows[i].pins, {zLvl, zOe, oLvl, oOe});
			rdchk("status", 8'h00, rows[i].stat);
			$display("test row %0d done", i);
		end
		// Writing zeros or reserved ones must leave both flags standing.
		wr(8'h00, 16'h0000);
		rdchk("status", 8'h00, 16'h0060);
		wr(8'h00, 16'h009F);
		rdchk("status", 8'h00, 16'h0060);
		wr(8'h00, 16'h0020);
		rdchk("status", 8'h00, 16'h0040);
		$display("test flag clear done");
		wr(8'h00, 16'h8000);
		#1 chkP("clear", 4'h1, {3'b000, clrReq});
		@(posedge ref_clk);
		#1 chkP("clear", 4'h0, {3'b000, clrReq});
		rdchk("status", 8'h00, 16'h0040);
		$display("test buffer clear done");
		// An event in the same cycle as the clearing write must leave the flag set.
		@(posedge ref_clk);
		regWrEn <= 1'b1;
		regAddr <= 8'h00;
		regWrData <= 16'h0020;
		evA <= 1'b1;
		@(posedge ref_clk);
		regWrEn <= 1'b0;
		evA <= 1'b0;
		rdchk("status", 8'h00, 16'h0060);
		$display("test set beats clear done");
		wr(8'h03, 16'hFFFF);
		rdchk("unmapped", 8'h03, 16'h0000);
		rdchk("mask", 8'h01, 16'h019F);
		$display("test unmapped done");
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		repeat (12) @(posedge ref_clk);
		sys_rst <= 1'b0;
		cfgNow <= 16'h0000;
		rdchk("mask", 8'h01, 16'h01FF);
		rdchk("pincfg", 8'h02, 16'h0000);
		rdchk("status", 8'h00, 16'h0000);
		chkP("pins", 4'b0001, {zLvl, zOe, oLvl, oOe});
		$display("test reset done");
		conclude();
	end
endmodule

// >>> sics_consts.svh
// Offsets, field positions, reset values and storage masks of the interrupt status block.
// Assumes inclusion by bare name from the interrupt status module.
`ifndef SICS_CONSTS_SVH
`define SICS_CONSTS_SVH

`define SICS_OFS_STATUS 8'h00
`define SICS_OFS_MASK 8'h01
`define SICS_OFS_PINCFG 8'h02

`define SICS_STAT_CLR_BIT 15
`define SICS_STAT_CNT_LSB 8
`define SICS_STAT_RSV_HI_BIT 7
`define SICS_STAT_SECOND_BIT 6
`define SICS_STAT_FIRST_BIT 5
`define SICS_STAT_RSV_LO_MASK 16'h001F
`define SICS_STAT_FLAG_RST 1'b0

`define SICS_MASK_THR_BIT 8
`define SICS_MASK_SECOND_BIT 6
`define SICS_MASK_FIRST_BIT 5
`define SICS_MASK_RST 16'h01FF
`define SICS_MASK_STORE 16'h01FF

`define SICS_PIN_ONE_DRV_BIT 9
`define SICS_PIN_ONE_POL_BIT 8
`define SICS_PIN_ZERO_ENA_BIT 2
`define SICS_PIN_ZERO_DRV_BIT 1
`define SICS_PIN_ZERO_POL_BIT 0
`define SICS_PINCFG_RST 16'h0000
`define SICS_PINCFG_STORE 16'h0307

`endif

// >>> sics_host_model.sv
// Host side of one interrupt pin: the board pull resistor and the sensed wire level.
// Assumes the bench sets the pull to the inactive level of the pin's polarity.
`timescale 1ns/100ps
module sics_host_model (
	input wire logic pinOut, // Level driven by the device.
	input wire logic pinOe, // High while the device drives.
	input wire logic pullLevel, // Level of the board resistor.
	output logic pinLevel // Wire level seen by the host.
);
	// ****************************************
	// Wire resolution
	// ****************************************
	// Released pin follows resistor.
	assign pinLevel = pinOe ? pinOut : pullLevel;
endmodule

// >>> sics_int_status.sv
// Interrupt status, event mask and interrupt pin configuration of the front end.
// Assumes a word-wide register port decoded from the serial interface, and
// event, count and threshold inputs from logic on the same clock.
`timescale 1ns/100ps
`include "sics_consts.svh"

// Functional notes
// [RQ1] Status high byte shows buffered bytes.
// [RQ2] Writing status bit 15 clears buffer.
// [RQ3] Reserved bit 7 cleared by writing one.
// [RQ4] Second slot event sets bit 6.
// [RQ5] First slot event sets bit 5.
// [RQ6] Event flags clear on one, keep on zero.
// [RQ7] Reserved bits 4:0 cleared by ones.
// [RQ8] Mask bit 8 gates threshold, resets one.
// [RQ9] Mask bit 6 gates second slot.
// [RQ10] Mask bit 5 gates first slot.
// [RQ11] Bit 9 selects pin one open drain.
// [RQ12] Bit 8 selects pin one polarity.
// [RQ13] Bit 2 low floats pin zero.
// [RQ14] Threshold interrupt while words exceed threshold.
// [RQ15] Bit 1 selects pin zero open drain.
// [RQ16] Bit 0 selects pin zero polarity.
// [RQ17] Interrupt is OR of unmasked events.
module sics_int_status #(
	parameter int WORD_CNT_W = 7,
	parameter int THR_W = 6
) (
	input wire logic ref_clk, // Block clock, 100 MHz.
	input wire logic sys_rst, // Synchronous reset, active high.
	input wire logic regWrEn, // Register write strobe.
	input wire logic regRdEn, // Register read strobe.
	input wire sics_pkg::sics_addr_t regAddr, // Register offset.
	input wire sics_pkg::sics_word_t regWrData, // Write data.
	output sics_pkg::sics_word_t regRdData, // Read data, one cycle after strobe.
	input wire logic [WORD_CNT_W-1:0] bufferWordCount, // Words held in the buffer.
	input wire logic [THR_W-1:0] bufferWordThreshold, // Threshold in words.
	input wire logic firstSlotEvent, // First slot sample pulse.
	input wire logic secondSlotEvent, // Second slot sample pulse.
	output logic bufferClearReq, // One-cycle buffer discard pulse.
	output logic intPinZeroOut, // Pin zero level.
	output logic intPinZeroOe, // Pin zero drive enable.
	output logic intPinOneOut, // Pin one level.
	output logic intPinOneOe // Pin one drive enable.
);
	import sics_pkg::*;

	sics_word_t regRdData_ff;
	sics_word_t maskReg_ff;
	sics_word_t pinCfg_ff;
	logic firstFlag_ff;
	logic secondFlag_ff;
	logic bufferClearReq_ff;
	logic [7:0] bufferedByteCount;
	logic thresholdEvent;
	logic irqNow;
	logic statusWrite;

	sics_pin_if pinZero ();
	sics_pin_if pinOne ();

	function automatic logic regHit(input logic strobe, input sics_addr_t addr,
		input sics_addr_t ofs);
		regHit = strobe && (addr == ofs);
	endfunction

	// ****************************************
	// Event flags
	// ****************************************
	assign statusWrite = regHit(regWrEn, regAddr, `SICS_OFS_STATUS);

	// [RQ5] [RQ6] first slot flag, set wins.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			firstFlag_ff <= `SICS_STAT_FLAG_RST;
		end else if (firstSlotEvent) begin
			firstFlag_ff <= 1'b1;
		end else if (statusWrite && regWrData[`SICS_STAT_FIRST_BIT]) begin
			firstFlag_ff <= 1'b0;
		end
	end

	// [RQ4] [RQ6] second slot flag, set wins.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			secondFlag_ff <= `SICS_STAT_FLAG_RST;
		end else if (secondSlotEvent) begin
			secondFlag_ff <= 1'b1;
		end else if (statusWrite && regWrData[`SICS_STAT_SECOND_BIT]) begin
			secondFlag_ff <= 1'b0;
		end
	end

	// [RQ2] buffer discard pulse.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			bufferClearReq_ff <= 1'b0;
		end else begin
			bufferClearReq_ff <= statusWrite && regWrData[`SICS_STAT_CLR_BIT];
		end
	end
	assign bufferClearReq = bufferClearReq_ff;

	// ****************************************
	// Mask and pin configuration registers
	// ****************************************
	// [RQ8] [RQ9] [RQ10] masks reset disabled.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			maskReg_ff <= `SICS_MASK_RST;
		end else if (regHit(regWrEn, regAddr, `SICS_OFS_MASK)) begin
			maskReg_ff <= regWrData & `SICS_MASK_STORE;
		end
	end

	// [RQ11] [RQ12] [RQ13] pin settings stored.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pinCfg_ff <= `SICS_PINCFG_RST;
		end else if (regHit(regWrEn, regAddr, `SICS_OFS_PINCFG)) begin
			pinCfg_ff <= regWrData & `SICS_PINCFG_STORE;
		end
	end

	// ****************************************
	// Interrupt and pins
	// ****************************************
	// [RQ1] two bytes per buffered word.
	assign bufferedByteCount = 8'({bufferWordCount, 1'b0});
	// [RQ14] level compare, clears itself.
	assign thresholdEvent = {1'b0, bufferWordCount} > (WORD_CNT_W + 1)'(bufferWordThreshold);
	// [RQ17] OR of unmasked events.
	assign irqNow = (thresholdEvent && !maskReg_ff[`SICS_MASK_THR_BIT])
		|| (firstFlag_ff && !maskReg_ff[`SICS_MASK_FIRST_BIT])
		|| (secondFlag_ff && !maskReg_ff[`SICS_MASK_SECOND_BIT]);

	// Both pins carry the same interrupt; only pin zero has an enable, so pin one
	// is driven from reset onward unless bit 9 selects open drain; bit 8 sets its polarity.
	assign pinZero.irq = irqNow;
	assign pinZero.enable = pinCfg_ff[`SICS_PIN_ZERO_ENA_BIT];
	assign pinZero.polarity = pinCfg_ff[`SICS_PIN_ZERO_POL_BIT];
	assign pinZero.driveSel = pinCfg_ff[`SICS_PIN_ZERO_DRV_BIT];
	assign pinOne.irq = irqNow;
	assign pinOne.enable = 1'b1;
	assign pinOne.polarity = pinCfg_ff[`SICS_PIN_ONE_POL_BIT];
	assign pinOne.driveSel = pinCfg_ff[`SICS_PIN_ONE_DRV_BIT];

	sics_pin_drive pinZeroDrive (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.pin(pinZero.drv)
	);

	sics_pin_drive pinOneDrive (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.pin(pinOne.drv)
	);

	assign intPinZeroOut = pinZero.pinOut;
	assign intPinZeroOe = pinZero.pinOe;
	assign intPinOneOut = pinOne.pinOut;
	assign intPinOneOe = pinOne.pinOe;

	// ****************************************
	// Read back
	// ****************************************
	// Reserved status bits have no hardware source, so a write of ones leaves
	// them at zero and they always read zero.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			regRdData_ff <= 16'h0000;
		end else if (regRdEn) begin
			case (regAddr)
				`SICS_OFS_STATUS: begin
					// [RQ1] [RQ3] [RQ7] status word layout.
					regRdData_ff <= 16'h0000;
					regRdData_ff[15:`SICS_STAT_CNT_LSB] <= bufferedByteCount;
					regRdData_ff[`SICS_STAT_SECOND_BIT] <= secondFlag_ff;
					regRdData_ff[`SICS_STAT_FIRST_BIT] <= firstFlag_ff;
				end
				`SICS_OFS_MASK: begin
					regRdData_ff <= maskReg_ff;
				end
				`SICS_OFS_PINCFG: begin
					regRdData_ff <= pinCfg_ff;
				end
				default: begin
					regRdData_ff <= 16'h0000;
				end
			endcase
		end
	end
	assign regRdData = regRdData_ff;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	a_first_set: assert property (firstSlotEvent |=> firstFlag_ff) // [RQ5]
		else $error("First slot flag not set.");
	a_second_set: assert property (secondSlotEvent |=> secondFlag_ff) // [RQ4]
		else $error("Second slot flag not set.");
	a_flag_clear: assert property (statusWrite && regWrData[`SICS_STAT_FIRST_BIT] // [RQ6]
		&& !firstSlotEvent |=> !firstFlag_ff)
		else $error("First slot flag not cleared by one.");
	a_flag_keep: assert property (statusWrite && !regWrData[`SICS_STAT_SECOND_BIT] // [RQ6]
		&& secondFlag_ff |=> secondFlag_ff)
		else $error("Second slot flag lost on zero write.");
	a_clear_pulse: assert property (statusWrite && regWrData[`SICS_STAT_CLR_BIT] // [RQ2]
		|=> bufferClearReq ##1 (!bufferClearReq
		|| $past(statusWrite && regWrData[`SICS_STAT_CLR_BIT])))
		else $error("Buffer clear pulse wrong.");
	a_count_read: assert property (regHit(regRdEn, regAddr, `SICS_OFS_STATUS) // [RQ1]
		|=> regRdData[15:8] == $past(bufferedByteCount))
		else $error("Byte count read wrong.");
	a_rsv_zero: assert property (regHit(regRdEn, regAddr, `SICS_OFS_STATUS) // [RQ7]
		|=> regRdData[7] == 1'b0 && regRdData[4:0] == 5'h00)
		else $error("Reserved status bits not zero.");
	a_thr_irq: assert property (thresholdEvent && !maskReg_ff[`SICS_MASK_THR_BIT] // [RQ14]
		|=> intPinOneOut != $past(pinOne.polarity))
		else $error("Threshold interrupt not on pin one.");
	a_mask_block: assert property (maskReg_ff[8] && maskReg_ff[6] && maskReg_ff[5]
		|-> !irqNow) // [RQ17]
		else $error("Masked events raise the interrupt.");
	a_mask_reset: assert property ($fell(sys_rst) |-> maskReg_ff == 16'h01FF) // [RQ8]
		else $error("Mask reset value wrong.");

	c_first_irq: cover property (firstSlotEvent && !maskReg_ff[5] ##2 intPinOneOut);
	c_set_clear: cover property (firstSlotEvent && statusWrite && regWrData[5]);
	c_thr_irq: cover property (thresholdEvent && !maskReg_ff[8]);
endmodule

// >>> sics_pin_drive.sv
// Registered driver for one interrupt pin: level, polarity and open-drain enable.
// Assumes irq and the settings are on ref_clk; the pad resolves the wire.
`timescale 1ns/100ps
module sics_pin_drive (
	input wire logic ref_clk, // Block clock.
	input wire logic sys_rst, // Synchronous reset, active high.
	sics_pin_if.drv pin // Settings in, pin signals out.
);
	import sics_pkg::*;

	logic pinOut_ff;
	logic pinOe_ff;

	// ****************************************
	// Pin level and enable
	// ****************************************
	// [RQ12] [RQ16] polarity sets level.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pinOut_ff <= 1'b0;
		end else begin
			pinOut_ff <= pin.irq ^ pin.polarity;
		end
	end

	// [RQ11] [RQ13] [RQ15] drive and float.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pinOe_ff <= 1'b0;
		end else begin
			pinOe_ff <= pin.enable & (~pin.driveSel | pin.irq);
		end
	end

	assign pin.pinOut = pinOut_ff;
	assign pin.pinOe = pinOe_ff;

	// ****************************************
	// Checks
	// ****************************************
	a_pin_level: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ12]
		1'b1 |=> pinOut_ff == ($past(pin.irq) ^ $past(pin.polarity)))
		else $error("Pin level does not follow interrupt and polarity.");
	a_pin_float: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ13]
		!pin.enable |=> !pinOe_ff)
		else $error("Disabled pin is driven.");
	a_open_drain: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ11]
		pin.enable && pin.driveSel |=> pinOe_ff == $past(pin.irq))
		else $error("Open-drain enable does not follow interrupt.");
	c_pin_open_drain: cover property (@(posedge ref_clk) disable iff (sys_rst)
		pin.driveSel && pin.irq ##1 pinOe_ff);
endmodule

// >>> sics_pin_if.sv
// Carrier between the status logic and one interrupt pin driver.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
interface sics_pin_if;
	logic irq;
	logic enable;
	logic polarity;
	logic driveSel;
	logic pinOut;
	logic pinOe;
	modport ctl (output irq, output enable, output polarity, output driveSel,
		input pinOut, input pinOe);
	modport drv (input irq, input enable, input polarity, input driveSel,
		output pinOut, output pinOe);
endinterface

// >>> sics_pkg.sv
// Types shared by the interrupt status block and its pin drivers.
// Assumes sics_consts.svh is on the include path.
package sics_pkg;
	typedef logic [15:0] sics_word_t;
	typedef logic [7:0] sics_addr_t;
endpackage
